// *** inc/txfbc_pkg.sv ***
/*
  Constants for the transmit FIFO block chain configuration block.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
package txfbc_pkg;
  // ==========================================================
  // Register byte offsets.
  localparam logic [11:0] OFF_START_SEL = 12'h980;
  localparam logic [11:0] OFF_START_DATA = 12'h984;
  localparam logic [11:0] OFF_LINK_SEL = 12'h990;
  localparam logic [11:0] OFF_LINK_DATA = 12'h994;
  localparam logic [11:0] OFF_MARK_SEL = 12'h9A0;
  localparam logic [11:0] OFF_MARK_DATA = 12'h9A4;
  // ==========================================================
  // Field layout and sizes.
  localparam int unsigned AV_AW = 12;
  localparam int unsigned BLK_W = 10;
  localparam int unsigned CH_W = 8;
  localparam int unsigned BUSY_BIT = 15;
  localparam int unsigned DIR_BIT = 14;
  localparam logic [15:0] LINK_SEL_MASK = 16'h43FF;
  localparam logic [15:0] CH_SEL_MASK = 16'h40FF;
  // ==========================================================
  // Reset values.
  localparam logic [15:0] SEL_RESET = 16'h0000;
  localparam logic [9:0] DATA_RESET = 10'h000;
  // ==========================================================
  // Indirect table indices.
  localparam logic [1:0] IDX_START = 2'h0;
  localparam logic [1:0] IDX_LINK = 2'h1;
  localparam logic [1:0] IDX_MARK = 2'h2;
  typedef enum logic [0:0] {
    TXFBC_IDLE = 1'b0,
    TXFBC_CAPTURE = 1'b1
  } txfbc_state_t;
endpackage

// *** testbench/tb_top.sv ***
/*
  Self-checking testbench for the transmit FIFO block chain configuration block.
  Assumes the design package and top module are compiled first; the bench acts as Avalon-MM master and engine.
*/
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import txfbc_pkg::*;
  // ==========================================================
  // Signals.
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] adr = 12'h000;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat;
  logic wreq;
  logic ptr_we = 1'b0;
  logic [7:0] ptr_ch = 8'h00;
  logic [9:0] ptr = 10'h000;
  logic [7:0] eng_ch = 8'h00;
  logic [9:0] eng_blk = 10'h000;
  logic [9:0] start_blk;
  logic [9:0] next_blk;
  logic lvl_v = 1'b0;
  logic [7:0] lvl_ch = 8'h00;
  logic [9:0] lvl_cnt = 10'h000;
  logic refill;
  logic [7:0] refill_ch;
  int n_errors = 0;
  int n_tests = 0;
  logic [9:0] link_m [1024];
  logic [9:0] blks [24];
  logic [11:0] sels [3] = '{OFF_START_SEL, OFF_LINK_SEL, OFF_MARK_SEL};

  txfbc_top txfbc_top_inst (
    .CLK_SYS_I(clk), .RESET_I(rst), .CE_I(1'b1),
    .AV_ADDRESS_I(adr), .AV_READ_I(rd_en), .AV_WRITE_I(wr_en), .AV_BYTEENABLE_I(4'h3),
    .AV_WRITEDATA_I(wdat), .AV_READDATA_O(rdat), .AV_WAITREQUEST_O(wreq),
    .ENG_PTR_WE_I(ptr_we), .ENG_PTR_CH_I(ptr_ch), .ENG_PTR_I(ptr), .ENG_CH_I(eng_ch),
    .ENG_START_BLK_O(start_blk), .ENG_BLK_I(eng_blk), .ENG_NEXT_BLK_O(next_blk),
    .LVL_VALID_I(lvl_v), .LVL_CH_I(lvl_ch), .LVL_COUNT_I(lvl_cnt),
    .DMA_REFILL_O(refill), .DMA_REFILL_CH_O(refill_ch)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Reporting.
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // ==========================================================
  // Bus master: holds the request until waitrequest is seen low.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    rd_en <= !w;
    wr_en <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n > 50) begin
        n_errors++;
        close_out();
      end
    end while (wreq !== 1'b0);
    q = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask

  // Expected select read-back: busy clear, direction and selector as written.
  function automatic logic [31:0] sel_exp(input logic dir, input logic [9:0] idx);
    return {17'h00000, dir, 4'h0, idx};
  endfunction

  // Indirect access: data first for stores, then select, then poll busy low.
  task automatic ind(input logic [11:0] sa, input logic dir, input logic [9:0] idx, input logic [9:0] d,
                     output logic [9:0] q);
    logic [31:0] r;
    int n;
    if (!dir) bus(1'b1, sa + 12'h004, {22'h000000, d}, r);
    bus(1'b1, sa, sel_exp(dir, idx), r);
    n = 0;
    do begin
      bus(1'b0, sa, 32'h0000_0000, r);
      if (n == 0 && dir) chk(32'(r[15]), 32'h0000_0001);
      n++;
    end while (r[15] !== 1'b0 && n < 20);
    if (r[15] !== 1'b0) begin
      n_errors++;
      close_out();
    end
    chk(r, sel_exp(dir, idx));
    bus(1'b0, sa + 12'h004, 32'h0000_0000, r);
    q = r[9:0];
  endtask

  // Level report; counts refill pulses in the following cycles.
  task automatic lvl(input logic [7:0] c, input logic [9:0] n, input logic e);
    int hits;
    logic [7:0] ch;
    hits = 0;
    ch = 8'h00;
    @(posedge clk);
    lvl_v <= 1'b1;
    lvl_ch <= c;
    lvl_cnt <= n;
    @(posedge clk);
    lvl_v <= 1'b0;
    repeat (4) begin
      @(negedge clk);
      if (refill === 1'b1) begin
        hits++;
        ch = refill_ch;
      end
    end
    chk(32'(hits), 32'(e));
    chk(32'(ch), e ? 32'(c) : 32'h0000_0000);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end

  // ==========================================================
  // Main sequence.
  initial begin
    logic [31:0] r;
    logic [9:0] q;
    logic [9:0] b;
    logic [9:0] l;
    logic [7:0] c;
    logic [9:0] m;
    logic [9:0] s;
    r = $urandom(81759);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (sels[i]) begin
      bus(1'b0, sels[i], 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
    end
    bus(1'b0, 12'h9B0, 32'h0000_0000, r);
    chk(r, 32'h0000_0000);
    for (int i = 0; i < 24; i++) begin
      b = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
      l = b + 10'h001 + 10'($urandom_range(0, 1022));
      blks[i] = b;
      link_m[b] = l;
      ind(OFF_LINK_SEL, 1'b0, b, l, q);
    end
    for (int i = 0; i < 24; i++) begin
      ind(OFF_LINK_SEL, 1'b1, blks[i], 10'h000, q);
      chk(32'(q), 32'(link_m[blks[i]]));
      @(posedge clk);
      eng_blk <= blks[i];
      @(posedge clk);
      @(negedge clk);
      chk(32'(next_blk), 32'(link_m[blks[i]]));
    end
    for (int i = 0; i < 12; i++) begin
      c = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      m = 10'($urandom_range(1, 8));
      s = 10'($urandom);
      ind(OFF_MARK_SEL, 1'b0, {2'h0, c}, m, q);
      ind(OFF_MARK_SEL, 1'b1, {2'h0, c}, 10'h000, q);
      chk(32'(q), 32'(m));
      fork
        ind(OFF_START_SEL, 1'b0, {2'h0, c}, s, q);
        begin
          repeat (4) @(posedge clk);
          ptr_we <= 1'b1;
          ptr_ch <= c + 8'h01;
          ptr <= 10'($urandom);
          repeat (2) @(posedge clk);
          ptr_we <= 1'b0;
        end
      join
      @(posedge clk);
      eng_ch <= c;
      @(posedge clk);
      @(negedge clk);
      chk(32'(start_blk), 32'(s));
      s = 10'($urandom);
      @(posedge clk);
      ptr_we <= 1'b1;
      ptr_ch <= c;
      ptr <= s;
      @(posedge clk);
      ptr_we <= 1'b0;
      ind(OFF_START_SEL, 1'b1, {2'h0, c}, 10'h000, q);
      chk(32'(q), 32'(s));
      lvl(c, m - 10'h001, 1'b1);
      lvl(c, m, 1'b1);
      lvl(c, m + 10'h001, 1'b0);
    end
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (sels[i]) begin
      bus(1'b0, sels[i], 32'h0000_0000, r);
      chk(r, 32'h0000_0000);
    end
    ind(OFF_MARK_SEL, 1'b0, 10'h000, 10'h000, q);
    lvl(8'h00, 10'h000, 1'b0);
    close_out();
  end
endmodule

// *** verilog/txfbc_ram.sv ***
/*
  Table with one write port and two synchronous read ports.
  Assumes one clock; reads return the old word on a same-cycle write.
*/
module txfbc_ram #(
  parameter int unsigned AW = 10,
  parameter int unsigned DW = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [DW-1:0] wdata_i,
  input wire logic [AW-1:0] raddr_a_i,
  output logic [DW-1:0] rdata_a_o,
  input wire logic [AW-1:0] raddr_b_i,
  output logic [DW-1:0] rdata_b_o
);
  // ==========================================================
  // Storage.
  logic [DW-1:0] mem [2**AW];

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  // ==========================================================
  // Read ports.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_a_o <= '0;
      rdata_b_o <= '0;
    end else if (ce_i) begin
      rdata_a_o <= mem[raddr_a_i];
      rdata_b_o <= mem[raddr_b_i];
    end
  end
endmodule

// *** verilog/txfbc_top.sv ***
/*
  Transmit FIFO block chain configuration: start pointers, block links and low water marks.
  Assumes an Avalon-MM master, an HDLC engine that reports its block pointer and a DMA refill consumer.
*/
// Implementation choice: the Avalon-MM interface to the registers.
module txfbc_top
  import txfbc_pkg::*;
#(
  parameter int unsigned BW = BLK_W,
  parameter int unsigned CW = CH_W
) (
  input wire logic CLK_SYS_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  input wire logic [AV_AW-1:0] AV_ADDRESS_I,
  input wire logic AV_READ_I,
  input wire logic AV_WRITE_I,
  input wire logic [3:0] AV_BYTEENABLE_I,
  input wire logic [31:0] AV_WRITEDATA_I,
  output logic [31:0] AV_READDATA_O,
  output logic AV_WAITREQUEST_O,
  input wire logic ENG_PTR_WE_I,
  input wire logic [CW-1:0] ENG_PTR_CH_I,
  input wire logic [BW-1:0] ENG_PTR_I,
  input wire logic [CW-1:0] ENG_CH_I,
  output logic [BW-1:0] ENG_START_BLK_O,
  input wire logic [BW-1:0] ENG_BLK_I,
  output logic [BW-1:0] ENG_NEXT_BLK_O,
  input wire logic LVL_VALID_I,
  input wire logic [CW-1:0] LVL_CH_I,
  input wire logic [BW-1:0] LVL_COUNT_I,
  output logic DMA_REFILL_O,
  output logic [CW-1:0] DMA_REFILL_CH_O
);
  // ==========================================================
  // State.
  txfbc_state_t state_ff, nxt_state;
  logic [15:0] sel_ff [3];
  logic [15:0] nxt_sel [3];
  logic [BW-1:0] data_ff [3];
  logic [BW-1:0] nxt_data [3];
  logic [1:0] cur_ff, nxt_cur;
  logic rd_done_ff, nxt_rd_done;
  logic [31:0] rdata_ff, nxt_rdata;
  logic lvl_v_ff, nxt_lvl_v;
  logic [BW-1:0] lvl_cnt_ff, nxt_lvl_cnt;
  logic [CW-1:0] lvl_ch_ff, nxt_lvl_ch;
  logic refill_ff, nxt_refill;
  logic [CW-1:0] refill_ch_ff, nxt_refill_ch;
  logic hit_sel, hit_data;
  logic [1:0] hit_k, gnt;
  logic any_busy;
  logic [2:0] ram_we;
  logic [BW-1:0] addr_a;
  logic [BW-1:0] q_a [3];
  logic [BW-1:0] mark_q_b;
  logic [15:0] rdv;
  logic start_we;
  logic [CW-1:0] start_waddr;
  logic [BW-1:0] start_wdata;

  // ==========================================================
  // Address decode.
  always_comb begin
    hit_sel = 1'b0;
    hit_data = 1'b0;
    hit_k = IDX_START;
    if (AV_ADDRESS_I == OFF_START_SEL) begin
      hit_sel = 1'b1;
    end else if (AV_ADDRESS_I == OFF_START_DATA) begin
      hit_data = 1'b1;
    end else if (AV_ADDRESS_I == OFF_LINK_SEL) begin
      hit_sel = 1'b1;
      hit_k = IDX_LINK;
    end else if (AV_ADDRESS_I == OFF_LINK_DATA) begin
      hit_data = 1'b1;
      hit_k = IDX_LINK;
    end else if (AV_ADDRESS_I == OFF_MARK_SEL) begin
      hit_sel = 1'b1;
      hit_k = IDX_MARK;
    end else if (AV_ADDRESS_I == OFF_MARK_DATA) begin
      hit_data = 1'b1;
      hit_k = IDX_MARK;
    end
    if (hit_sel) begin
      rdv = sel_ff[hit_k];
    end else if (hit_data) begin
      rdv = {{(16-BW){1'b0}}, data_ff[hit_k]};
    end else begin
      rdv = 16'h0000;
    end
  end

  // ==========================================================
  // Indirect access arbitration.
  always_comb begin
    any_busy = sel_ff[IDX_START][BUSY_BIT] | sel_ff[IDX_LINK][BUSY_BIT] | sel_ff[IDX_MARK][BUSY_BIT];
    if (sel_ff[IDX_START][BUSY_BIT]) begin
      gnt = IDX_START;
    end else if (sel_ff[IDX_LINK][BUSY_BIT]) begin
      gnt = IDX_LINK;
    end else begin
      gnt = IDX_MARK;
    end
    addr_a = sel_ff[gnt][BW-1:0];
  end

  // ==========================================================
  // Register file, bus answer and indirect sequencer.
  always_comb begin
    nxt_state = state_ff;
    nxt_sel = sel_ff;
    nxt_data = data_ff;
    nxt_cur = cur_ff;
    nxt_rd_done = rd_done_ff;
    nxt_rdata = rdata_ff;
    ram_we = 3'h0;
    if (CE_I) begin
      nxt_rd_done = AV_READ_I && !rd_done_ff;
      if (AV_READ_I && !rd_done_ff) begin
        nxt_rdata = {16'h0000, rdv};
      end
      case (state_ff)
        TXFBC_IDLE: begin
          if (any_busy) begin
            if (sel_ff[gnt][DIR_BIT]) begin
              nxt_state = TXFBC_CAPTURE;
              nxt_cur = gnt;
            end else if (!(gnt == IDX_START && ENG_PTR_WE_I)) begin
              ram_we[gnt] = 1'b1;
              nxt_sel[gnt][BUSY_BIT] = 1'b0;
            end
          end
        end
        TXFBC_CAPTURE: begin
          nxt_state = TXFBC_IDLE;
        end
        default: begin
          nxt_state = TXFBC_IDLE;
        end
      endcase
      if (AV_WRITE_I && hit_sel && !sel_ff[hit_k][BUSY_BIT]) begin
        if (AV_BYTEENABLE_I[0]) begin
          nxt_sel[hit_k][7:0] = AV_WRITEDATA_I[7:0];
        end
        if (AV_BYTEENABLE_I[1]) begin
          nxt_sel[hit_k][15:8] = {1'b1, AV_WRITEDATA_I[14:8]};
        end
        nxt_sel[hit_k] = nxt_sel[hit_k] & ((hit_k == IDX_LINK) ? LINK_SEL_MASK : CH_SEL_MASK) |
          (nxt_sel[hit_k] & 16'h8000);
      end else if (AV_WRITE_I && hit_data) begin
        if (AV_BYTEENABLE_I[0]) begin
          nxt_data[hit_k][7:0] = AV_WRITEDATA_I[7:0];
        end
        if (AV_BYTEENABLE_I[1]) begin
          nxt_data[hit_k][BW-1:8] = AV_WRITEDATA_I[BW-1:8];
        end
      end
      if (state_ff == TXFBC_CAPTURE) begin
        nxt_data[cur_ff] = q_a[cur_ff];
        nxt_sel[cur_ff][BUSY_BIT] = 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      state_ff <= TXFBC_IDLE;
      for (int k = 0; k < 3; k++) begin
        sel_ff[k] <= SEL_RESET;
        data_ff[k] <= DATA_RESET;
      end
      cur_ff <= IDX_START;
      rd_done_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      state_ff <= nxt_state;
      sel_ff <= nxt_sel;
      data_ff <= nxt_data;
      cur_ff <= nxt_cur;
      rd_done_ff <= nxt_rd_done;
      rdata_ff <= nxt_rdata;
    end
  end

  assign AV_READDATA_O = rdata_ff;
  assign AV_WAITREQUEST_O = !CE_I || (AV_READ_I && !rd_done_ff);

  // ==========================================================
  // Tables. The engine's pointer update wins the start table write port.
  always_comb begin
    start_we = ENG_PTR_WE_I || ram_we[IDX_START];
    start_waddr = ENG_PTR_WE_I ? ENG_PTR_CH_I : sel_ff[IDX_START][CW-1:0];
    start_wdata = ENG_PTR_WE_I ? ENG_PTR_I : data_ff[IDX_START];
  end

  txfbc_ram #(.AW(CW), .DW(BW)) u_start_ram (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .we_i(start_we),
    .waddr_i(start_waddr),
    .wdata_i(start_wdata),
    .raddr_a_i(addr_a[CW-1:0]),
    .rdata_a_o(q_a[IDX_START]),
    .raddr_b_i(ENG_CH_I),
    .rdata_b_o(ENG_START_BLK_O)
  );

  txfbc_ram #(.AW(BW), .DW(BW)) u_link_ram (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .we_i(ram_we[IDX_LINK]),
    .waddr_i(sel_ff[IDX_LINK][BW-1:0]),
    .wdata_i(data_ff[IDX_LINK]),
    .raddr_a_i(addr_a),
    .rdata_a_o(q_a[IDX_LINK]),
    .raddr_b_i(ENG_BLK_I),
    .rdata_b_o(ENG_NEXT_BLK_O)
  );

  txfbc_ram #(.AW(CW), .DW(BW)) u_mark_ram (
    .clk_i(CLK_SYS_I),
    .rst_i(RESET_I),
    .ce_i(CE_I),
    .we_i(ram_we[IDX_MARK]),
    .waddr_i(sel_ff[IDX_MARK][CW-1:0]),
    .wdata_i(data_ff[IDX_MARK]),
    .raddr_a_i(addr_a[CW-1:0]),
    .rdata_a_o(q_a[IDX_MARK]),
    .raddr_b_i(LVL_CH_I),
    .rdata_b_o(mark_q_b)
  );

  // ==========================================================
  // Low water mark refill request.
  always_comb begin
    nxt_lvl_v = lvl_v_ff;
    nxt_lvl_cnt = lvl_cnt_ff;
    nxt_lvl_ch = lvl_ch_ff;
    nxt_refill = refill_ff;
    nxt_refill_ch = refill_ch_ff;
    if (CE_I) begin
      nxt_lvl_v = LVL_VALID_I;
      nxt_lvl_cnt = LVL_COUNT_I;
      nxt_lvl_ch = LVL_CH_I;
      nxt_refill = lvl_v_ff && (mark_q_b != '0) && (lvl_cnt_ff <= mark_q_b);
      nxt_refill_ch = lvl_ch_ff;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RESET_I) begin
    if (RESET_I) begin
      lvl_v_ff <= 1'b0;
      lvl_cnt_ff <= '0;
      lvl_ch_ff <= '0;
      refill_ff <= 1'b0;
      refill_ch_ff <= '0;
    end else begin
      lvl_v_ff <= nxt_lvl_v;
      lvl_cnt_ff <= nxt_lvl_cnt;
      lvl_ch_ff <= nxt_lvl_ch;
      refill_ff <= nxt_refill;
      refill_ch_ff <= nxt_refill_ch;
    end
  end

  assign DMA_REFILL_O = refill_ff;
  assign DMA_REFILL_CH_O = refill_ch_ff;

  // ==========================================================
  // Assertions.
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RESET_I || !CE_I);

  logic acc_sel;
  assign acc_sel = AV_WRITE_I && hit_sel && !sel_ff[hit_k][BUSY_BIT] && AV_BYTEENABLE_I[1] && CE_I;

  sequence s_link_rd_go;
    acc_sel && hit_k == IDX_LINK && AV_WRITEDATA_I[DIR_BIT];
  endsequence

  sequence s_link_busy_wait;
    sel_ff[IDX_LINK][BUSY_BIT] ##[1:5] !sel_ff[IDX_LINK][BUSY_BIT];
  endsequence

  property p_busy_on;
    acc_sel |=> sel_ff[$past(hit_k)][BUSY_BIT];
  endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy not set by select write");

  property p_link_rd;
    s_link_rd_go |=> s_link_busy_wait;
  endproperty
  a_link_rd: assert property (p_link_rd) else $error("link read busy did not clear in time");

  property p_link_cap;
    (state_ff == TXFBC_CAPTURE && cur_ff == IDX_LINK) |=>
      !sel_ff[IDX_LINK][BUSY_BIT] && data_ff[IDX_LINK] == $past(q_a[IDX_LINK]);
  endproperty
  a_link_cap: assert property (p_link_cap) else $error("link data not captured");

  property p_link_wr;
    ram_we[IDX_LINK] |-> !sel_ff[IDX_LINK][DIR_BIT] ##1 !sel_ff[IDX_LINK][BUSY_BIT];
  endproperty
  a_link_wr: assert property (p_link_wr) else $error("link write did not end busy");

  property p_blk_addr;
    (state_ff == TXFBC_IDLE && any_busy && gnt == IDX_LINK) |-> addr_a == sel_ff[IDX_LINK][BW-1:0];
  endproperty
  a_blk_addr: assert property (p_blk_addr) else $error("block selector not used as address");

  property p_start_cap;
    (state_ff == TXFBC_CAPTURE && cur_ff == IDX_START) |=> data_ff[IDX_START] == $past(q_a[IDX_START]);
  endproperty
  a_start_cap: assert property (p_start_cap) else $error("start pointer not captured");

  property p_ch_addr;
    (state_ff == TXFBC_IDLE && gnt == IDX_MARK && any_busy) |-> addr_a[BW-1:CW] == '0;
  endproperty
  a_ch_addr: assert property (p_ch_addr) else $error("channel selector wider than eight bits");

  property p_mark_wr;
    ram_we[IDX_MARK] |-> !sel_ff[IDX_START][BUSY_BIT] && !sel_ff[IDX_LINK][BUSY_BIT];
  endproperty
  a_mark_wr: assert property (p_mark_wr) else $error("mark write out of order");

  property p_refill;
    (lvl_v_ff && mark_q_b != '0 && lvl_cnt_ff <= mark_q_b) |=> DMA_REFILL_O && DMA_REFILL_CH_O == $past(lvl_ch_ff);
  endproperty
  a_refill: assert property (p_refill) else $error("refill request missing");

  property p_eng_prio;
    (state_ff == TXFBC_IDLE && gnt == IDX_START && sel_ff[IDX_START][BUSY_BIT] &&
      !sel_ff[IDX_START][DIR_BIT] && ENG_PTR_WE_I) |=> sel_ff[IDX_START][BUSY_BIT];
  endproperty
  a_eng_prio: assert property (p_eng_prio) else $error("start write ran over engine update");

  property p_reset;
    disable iff (1'b0) ($past(RESET_I) && !RESET_I) |->
      sel_ff[IDX_START] == SEL_RESET && sel_ff[IDX_LINK] == SEL_RESET && sel_ff[IDX_MARK] == SEL_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("select registers not zero after reset");
endmodule
